// >>> rtl/lhm_ctrl.sv
// Fail-safe controller top: serial register slave, mode states, channel drive.
// Assumes link pins are asynchronous to clk_i; mode requests, stored settings,
// undervoltage and fail-silent inputs come from logic on clk_i.
`timescale 1ns/1ps

module lhm_ctrl #(
  parameter int unsigned TOUT_BASE_CYC = lhm_pkg::TOUT_BASE_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       csb_n_i,
  input  wire logic       sclk_i,
  input  wire logic       sdi_i,
  output logic            sdo_o,
  output logic            sdo_oe_n_o,
  input  wire logic [2:0] pwm_i,
  input  wire logic       nvm_access_req_i,
  input  wire logic       nvm_use_req_i,
  input  wire logic       nvm_unused_req_i,
  input  wire logic       undervoltage_i,
  input  wire logic       fail_silent_i,
  input  wire logic [7:0] nv_current_ch1_i,
  input  wire logic [7:0] nv_current_ch2_i,
  input  wire logic [7:0] nv_current_ch3_i,
  input  wire logic [5:0] failsafe_channel_override_i,
  output logic [7:0]      led_current_ch1_o,
  output logic [7:0]      led_current_ch2_o,
  output logic [7:0]      led_current_ch3_o,
  output logic [2:0]      ch_on_o,
  output logic            failsafe_o,
  output logic            nvm_allowed_o
);

  lhm_pkg::lhm_state_t state_r;
  lhm_pkg::lhm_state_t state_nxt;

  logic        csb_s1, csb_s2, csb_d;
  logic        sclk_s1, sclk_s2, sclk_d;
  logic        sdi_s1, sdi_s2;
  logic [2:0]  pwm_s1, pwm_s2;
  logic        sclk_fall, sclk_rise, csb_fall, csb_rise;
  logic [4:0]  cnt_r;
  logic [15:0] rx_r;
  logic [7:0]  tx_r;
  logic        sdo_r;
  logic        wr_stb, wr_ok, fsc_wr;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [2:0]  wr_exit;
  logic [2:0]  exit_r;
  logic [2:0]  tout_r;
  logic [1:0]  step_r;
  logic        exit_done;
  logic        refresh;
  logic        expire;
  logic        silent_r;
  logic [7:0]  cur1_r, cur2_r, cur3_r;
  logic [5:0]  ovr_r;
  logic [7:0]  fsc_rd;
  logic [7:0]  rd_data;
  logic        drive_ok;
  logic [2:0]  ch_on_r;

  // Two-flop synchronisers for every pin from outside the clock domain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      csb_s1  <= 1'b1;
      csb_s2  <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
      pwm_s1  <= 3'h0;
      pwm_s2  <= 3'h0;
    end else begin
      csb_s1  <= csb_n_i;
      csb_s2  <= csb_s1;
      sclk_s1 <= sclk_i;
      sclk_s2 <= sclk_s1;
      sdi_s1  <= sdi_i;
      sdi_s2  <= sdi_s1;
      pwm_s1  <= pwm_i;
      pwm_s2  <= pwm_s1;
    end
  end

  // Edge history taken from the second stage only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      csb_d  <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      csb_d  <= csb_s2;
      sclk_d <= sclk_s2;
    end
  end

  assign sclk_fall = sclk_d && !sclk_s2;
  assign sclk_rise = !sclk_d && sclk_s2;
  assign csb_fall  = csb_d && !csb_s2;
  assign csb_rise  = !csb_d && csb_s2;

  // Receive: sample on falling clock, keep the first 16 bits of a frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 5'h0;
      rx_r  <= 16'h0000;
    end else if (csb_s2) begin
      cnt_r <= 5'h0;
    end else if (sclk_fall && cnt_r != lhm_pkg::FRAME_BITS) begin
      rx_r  <= {rx_r[14:0], sdi_s2};
      cnt_r <= cnt_r + 5'h1;
    end
  end

  // Frames shorter than 16 bits are dropped at chip-select release
  assign wr_stb  = csb_rise && (cnt_r == lhm_pkg::FRAME_BITS) && !rx_r[lhm_pkg::RW_BIT];
  assign wr_addr = rx_r[14:8];
  assign wr_data = rx_r[7:0];
  assign wr_exit = wr_data[lhm_pkg::EXIT_HI:lhm_pkg::EXIT_LO];
  assign fsc_wr  = wr_stb && (wr_addr == lhm_pkg::ADDR_FSC);

  // Only the control register is writable while in fail-safe
  assign wr_ok = wr_stb && ((state_r != lhm_pkg::ST_FAILSAFE) || fsc_wr);

  // Control register readback: live status and configuration flags
  always_comb begin
    fsc_rd = 8'h00;
    fsc_rd[lhm_pkg::STATUS_BIT] = (state_r == lhm_pkg::ST_FAILSAFE);
    fsc_rd[lhm_pkg::EXIT_HI:lhm_pkg::EXIT_LO] = exit_r;
    fsc_rd[lhm_pkg::TOUT_HI:lhm_pkg::TOUT_LO] = tout_r;
    fsc_rd[lhm_pkg::CFG_BIT] = (state_r == lhm_pkg::ST_NVM_USE);
  end

  // Read mux by the address already shifted in; unmapped reads as zero
  always_comb begin
    unique case (rx_r[6:0])
      lhm_pkg::ADDR_FSC:  rd_data = fsc_rd;
      lhm_pkg::ADDR_CUR1: rd_data = cur1_r;
      lhm_pkg::ADDR_CUR2: rd_data = cur2_r;
      lhm_pkg::ADDR_CUR3: rd_data = cur3_r;
      default:            rd_data = 8'h00;
    endcase
  end

  // Transmit: first byte is the control register, second the addressed one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_r  <= 8'h00;
      sdo_r <= 1'b0;
    end else if (csb_fall) begin
      sdo_r <= fsc_rd[7];
      tx_r  <= {fsc_rd[6:0], 1'b0};
    end else if (!csb_s2 && sclk_rise) begin
      if (cnt_r == lhm_pkg::ADDR_BITS) begin
        sdo_r <= rd_data[7];
        tx_r  <= {rd_data[6:0], 1'b0};
      end else begin
        sdo_r <= tx_r[7];
        tx_r  <= {tx_r[6:0], 1'b0};
      end
    end
  end

  assign sdo_o      = sdo_r;
  assign sdo_oe_n_o = csb_s2; // Released while deselected

  // Refresh needs 111 in the exit bits; time-out is taken from the same write
  assign refresh = fsc_wr && (wr_exit == lhm_pkg::EXIT_REFRESH);

  lhm_timeout #(
    .BASE_CYC (TOUT_BASE_CYC)
  ) u_timeout (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (state_r == lhm_pkg::ST_NORMAL),
    .restart_i (refresh),
    .sel_i     (tout_r),
    .expire_o  (expire)
  );

  // Control register fields take writes in every state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exit_r <= lhm_pkg::EXIT_RST;
      tout_r <= lhm_pkg::TOUT_RST;
    end else if (fsc_wr) begin
      exit_r <= wr_exit;
      tout_r <= wr_data[lhm_pkg::TOUT_HI:lhm_pkg::TOUT_LO];
    end
  end

  // Exit progress; any other value starts over, a new 001 re-arms step one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_r <= 2'h0;
    end else if (state_r != lhm_pkg::ST_FAILSAFE) begin
      step_r <= 2'h0;
    end else if (fsc_wr) begin
      unique case (wr_exit)
        lhm_pkg::EXIT_STEP1: step_r <= 2'h1;
        lhm_pkg::EXIT_STEP2: step_r <= (step_r == 2'h1) ? 2'h2 : 2'h0;
        default:             step_r <= 2'h0;
      endcase
    end
  end

  assign exit_done = fsc_wr && (state_r == lhm_pkg::ST_FAILSAFE) &&
                     (wr_exit == lhm_pkg::EXIT_STEP3) && (step_r == 2'h2);

  // Mode state: NVM Use and not-in-use hold until power-on reset
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lhm_pkg::ST_NORMAL: begin
        if (expire) begin
          state_nxt = lhm_pkg::ST_FAILSAFE;
        end else if (nvm_access_req_i) begin
          state_nxt = lhm_pkg::ST_NVM_ACCESS;
        end
      end
      lhm_pkg::ST_FAILSAFE: begin
        if (exit_done) begin
          state_nxt = lhm_pkg::ST_NORMAL;
        end
      end
      lhm_pkg::ST_NVM_ACCESS: begin
        if (nvm_use_req_i) begin
          state_nxt = lhm_pkg::ST_NVM_USE;
        end else if (nvm_unused_req_i) begin
          state_nxt = lhm_pkg::ST_NVM_UNUSED;
        end else if (!nvm_access_req_i) begin
          state_nxt = lhm_pkg::ST_NORMAL;
        end
      end
      lhm_pkg::ST_NVM_USE:    state_nxt = lhm_pkg::ST_NVM_USE;
      lhm_pkg::ST_NVM_UNUSED: state_nxt = lhm_pkg::ST_NVM_UNUSED;
      default:                state_nxt = lhm_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= lhm_pkg::ST_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Control registers: stored settings load on entry, else gated host writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur1_r <= lhm_pkg::CUR_RST;
      cur2_r <= lhm_pkg::CUR_RST;
      cur3_r <= lhm_pkg::CUR_RST;
      ovr_r  <= lhm_pkg::OVR_RST;
    end else if (state_r == lhm_pkg::ST_NORMAL && expire) begin
      cur1_r <= nv_current_ch1_i;
      cur2_r <= nv_current_ch2_i;
      cur3_r <= nv_current_ch3_i;
      ovr_r  <= failsafe_channel_override_i;
    end else if (wr_ok) begin
      unique case (wr_addr)
        lhm_pkg::ADDR_CUR1: cur1_r <= wr_data;
        lhm_pkg::ADDR_CUR2: cur2_r <= wr_data;
        lhm_pkg::ADDR_CUR3: cur3_r <= wr_data;
        default:            cur1_r <= cur1_r;
      endcase
    end
  end

  // Fail-silent latches until power-on reset, in any mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      silent_r <= 1'b0;
    end else if (fail_silent_i) begin
      silent_r <= 1'b1;
    end
  end

  // NVM Use and not-in-use force channel outputs off; current register writes still land
  assign drive_ok = !undervoltage_i && !silent_r && !fail_silent_i &&
                    (state_r != lhm_pkg::ST_NVM_USE) &&
                    (state_r != lhm_pkg::ST_NVM_UNUSED);

  // Channel drive: off while drive_ok is low, else override in fail-safe, PWM pins otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_on_r <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!drive_ok) begin
          ch_on_r[i] <= 1'b0;
        end else if (state_r == lhm_pkg::ST_FAILSAFE) begin
          if (ovr_r[2*i +: 2] == lhm_pkg::OVR_OFF) begin
            ch_on_r[i] <= 1'b0;
          end else if (ovr_r[2*i +: 2] == lhm_pkg::OVR_ON) begin
            ch_on_r[i] <= 1'b1;
          end else begin
            ch_on_r[i] <= pwm_s2[i];
          end
        end else begin
          ch_on_r[i] <= pwm_s2[i];
        end
      end
    end
  end

  assign ch_on_o           = ch_on_r;
  assign led_current_ch1_o = cur1_r;
  assign led_current_ch2_o = cur2_r;
  assign led_current_ch3_o = cur3_r;
  assign failsafe_o        = (state_r == lhm_pkg::ST_FAILSAFE);
  assign nvm_allowed_o     = (state_r == lhm_pkg::ST_NVM_USE);

endmodule : lhm_ctrl

// >>> pkg/lhm_pkg.sv
// Constants, register layout and state type for the fail-safe (limp-home) controller.
// Assumes a 100 MHz core clock and a host reaching the registers over the serial link.

package lhm_pkg;

  // Register addresses on the serial link
  localparam logic [6:0] ADDR_FSC  = 7'h33;
  localparam logic [6:0] ADDR_CUR1 = 7'h02;
  localparam logic [6:0] ADDR_CUR2 = 7'h03;
  localparam logic [6:0] ADDR_CUR3 = 7'h04;

  // Field positions in the fail-safe control register
  localparam int STATUS_BIT = 7;
  localparam int EXIT_HI    = 6;
  localparam int EXIT_LO    = 4;
  localparam int TOUT_HI    = 3;
  localparam int TOUT_LO    = 1;
  localparam int CFG_BIT    = 0;

  // Exit-bit codes
  localparam logic [2:0] EXIT_REFRESH = 3'h7;
  localparam logic [2:0] EXIT_STEP1   = 3'h1;
  localparam logic [2:0] EXIT_STEP2   = 3'h2;
  localparam logic [2:0] EXIT_STEP3   = 3'h4;

  // Per-channel override codes (01 and 11 follow the pin)
  localparam logic [1:0] OVR_OFF = 2'h0;
  localparam logic [1:0] OVR_ON  = 2'h2;

  // Values after reset
  localparam logic [2:0] EXIT_RST = 3'h0;
  localparam logic [2:0] TOUT_RST = 3'h0;
  localparam logic [7:0] CUR_RST  = 8'h00;
  localparam logic [5:0] OVR_RST  = 6'h00;

  // Serial frame: R/W bit, 7 address bits, 8 data bits
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_BITS  = 5'h08;
  localparam int         RW_BIT     = 15;

  // Timing: setting n (1..8) lasts n base units
  localparam int          CLK_KHZ       = 100_000;
  localparam int          TOUT_BASE_MS  = 10;
  localparam int unsigned TOUT_BASE_CYC = TOUT_BASE_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_FAILSAFE,
    ST_NVM_ACCESS,
    ST_NVM_USE,
    ST_NVM_UNUSED
  } lhm_state_t;

endpackage : lhm_pkg

// >>> rtl/lhm_timeout.sv
// Refresh time-out timer: a base-unit divider and a unit counter.
// Assumes run, restart and select come from logic on the same clock.
`timescale 1ns/1ps

module lhm_timeout #(
  parameter int unsigned BASE_CYC = lhm_pkg::TOUT_BASE_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic       restart_i,
  input  wire logic [2:0] sel_i,
  output logic            expire_o
);

  logic [31:0] div_r;
  logic        tick;
  logic [3:0]  units_r;
  logic        done_r;
  logic [3:0]  limit;

  // Setting n lasts n units, code 000 is setting one
  assign limit = {1'b0, sel_i} + 4'h1;
  assign tick  = (div_r == BASE_CYC[31:0] - 32'h1);

  // Base-unit divider, held at zero while stopped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 32'h0;
    end else if (!run_i || restart_i || tick) begin
      div_r <= 32'h0;
    end else begin
      div_r <= div_r + 32'h1;
    end
  end

  // Unit counter; compare with >= so a shortened setting still expires
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      units_r <= 4'h0;
      done_r  <= 1'b0;
    end else if (!run_i || restart_i) begin
      units_r <= 4'h0;
      done_r  <= 1'b0;
    end else if (!done_r && units_r >= limit) begin
      done_r  <= 1'b1;
    end else if (tick && units_r != 4'hF) begin
      units_r <= units_r + 4'h1;
    end
  end

  // One pulse per expiry, then quiet until restarted
  assign expire_o = run_i && !restart_i && !done_r && (units_r >= limit);

endmodule : lhm_timeout

// >>> verification/lhm_host_model.sv
// Host model: SPI master that frames 16-bit words toward the controller.
// Assumes the bench calls its tasks hierarchically; sclk idles low between frames.
`timescale 1ns/1ps

module lhm_host_model (
  input  wire logic sdo_i,
  input  wire logic sdo_oe_n_i,
  output logic      csb_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  // Link idle: chip select high, clock parked low
  initial begin
    csb_n_o = 1'b1;
    sclk_o  = 1'b0;
    sdi_o   = 1'b0;
  end

  // One frame, MSB first; shift on rise, device samples on fall
  task automatic xfer(input logic [15:0] word, output logic [7:0] rd);
    rd      = 8'h00;
    csb_n_o = 1'b0;
    #80;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b1;
      sdi_o  = word[i];
      #80;
      // Released sdo reads unknown so a float never passes
      if (i < 8) rd[i] = sdo_oe_n_i ? 1'bx : sdo_i;
      sclk_o = 1'b0;
      #80;
    end
    csb_n_o = 1'b1;
    sdi_o   = ~sdi_o;  // Released line shows no stale bit
    #100;  // Covers csb high time and the commit
  endtask : xfer

  // Refresh carries the time-out choice in the same write
  task automatic refresh(input logic [2:0] code);
    logic [7:0] r;
    xfer({1'b0, lhm_pkg::ADDR_FSC, 1'b0, lhm_pkg::EXIT_REFRESH, code, 1'b0}, r);
  endtask : refresh

  // Three ordered writes that release fail-safe
  task automatic exit_seq(input logic [2:0] code);
    logic [7:0] r;
    xfer({1'b0, lhm_pkg::ADDR_FSC, 1'b0, lhm_pkg::EXIT_STEP1, code, 1'b0}, r);
    xfer({1'b0, lhm_pkg::ADDR_FSC, 1'b0, lhm_pkg::EXIT_STEP2, code, 1'b0}, r);
    xfer({1'b0, lhm_pkg::ADDR_FSC, 1'b0, lhm_pkg::EXIT_STEP3, code, 1'b0}, r);
  endtask : exit_seq
endmodule : lhm_host_model

// >>> verification/lhm_ctrl_chk.sv
// Checker for the fail-safe controller, watching top-level ports only.
// Assumes one clock domain and the async active-high reset of the block.
`timescale 1ns/1ps

module lhm_ctrl_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       csb_n_i,
  input wire logic       sdo_oe_n_o,
  input wire logic       nvm_access_req_i,
  input wire logic       undervoltage_i,
  input wire logic       fail_silent_i,
  input wire logic [7:0] nv_current_ch1_i,
  input wire logic [5:0] failsafe_channel_override_i,
  input wire logic [7:0] led_current_ch1_o,
  input wire logic [2:0] ch_on_o,
  input wire logic       failsafe_o,
  input wire logic       nvm_allowed_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Store access and fail-safe never coexist
  chk_nvm_not_fs: assert property (nvm_allowed_o |-> !failsafe_o)
    else $error("store access while in fail-safe");
  chk_nvm_outputs_off: assert property (
    nvm_allowed_o && $past(nvm_allowed_o) |-> ch_on_o == 3'h0)
    else $error("channel on in NVM Use");
  chk_use_sticky: assert property (nvm_allowed_o |=> nvm_allowed_o)
    else $error("NVM Use left without reset");
  chk_uv_off: assert property (undervoltage_i |=> ch_on_o == 3'h0)
    else $error("channel on during undervoltage");
  chk_silent_latch: assert property (fail_silent_i |=> (ch_on_o == 3'h0) [*8])
    else $error("fail-silent recovered by itself");
  chk_entry_load: assert property (
    $rose(failsafe_o) |-> led_current_ch1_o == $past(nv_current_ch1_i))
    else $error("stored current not loaded on entry");
  chk_override_off: assert property (failsafe_o && $past(failsafe_o)
    && failsafe_channel_override_i[1:0] == lhm_pkg::OVR_OFF |-> !ch_on_o[0])
    else $error("forced-off channel is on");
  chk_regs_locked: assert property (
    failsafe_o && $past(failsafe_o) |-> $stable(led_current_ch1_o))
    else $error("control register changed in fail-safe");
  chk_timer_held: assert property ($rose(failsafe_o) |-> !$past(nvm_access_req_i, 2))
    else $error("fail-safe entered during store access");
  chk_link_alive: assert property ($fell(csb_n_i) |-> ##[1:4] !sdo_oe_n_o)
    else $error("sdo not enabled after select");

  cover property ($rose(failsafe_o));
  cover property ($fell(failsafe_o));
  cover property ($rose(nvm_allowed_o));
endmodule : lhm_ctrl_chk

// >>> verification/test_lhm_ctrl.sv
// Self-checking bench for the fail-safe controller with an SPI host model.
// Assumes a shortened time-out base unit; bench inputs change at falling clk edges.
`timescale 1ns/1ps

module test_lhm_ctrl;
  localparam int BASE = 400;  // Short base unit keeps the run brief
  logic       clk_i, rst_i, csb_n_i, sclk_i, sdi_i, sdo_o, sdo_oe_n_o;
  logic       nvm_access_req_i, nvm_use_req_i, nvm_unused_req_i;
  logic       undervoltage_i, fail_silent_i, failsafe_o, nvm_allowed_o;
  logic [2:0] pwm_i, ch_on_o;
  logic [5:0] ovr;
  logic [7:0] nv1, nv2, nv3, cur1, cur2, cur3, rb;
  int         err_count = 0;
  int         compares  = 0;
  int         cycles    = 0;

  lhm_ctrl #(.TOUT_BASE_CYC(BASE)) lhm_ctrl_i (.clk_i, .rst_i, .csb_n_i, .sclk_i, .sdi_i,
    .sdo_o, .sdo_oe_n_o, .pwm_i, .nvm_access_req_i, .nvm_use_req_i, .nvm_unused_req_i,
    .undervoltage_i, .fail_silent_i, .nv_current_ch1_i(nv1), .nv_current_ch2_i(nv2),
    .nv_current_ch3_i(nv3), .failsafe_channel_override_i(ovr), .led_current_ch1_o(cur1),
    .led_current_ch2_o(cur2), .led_current_ch3_o(cur3), .ch_on_o, .failsafe_o,
    .nvm_allowed_o);
  lhm_host_model lhm_host_model_i (.sdo_i(sdo_o), .sdo_oe_n_i(sdo_oe_n_o),
    .csb_n_o(csb_n_i), .sclk_o(sclk_i), .sdi_o(sdi_i));

  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    lhm_host_model_i.xfer({1'b0, a, d}, r);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] r);
    lhm_host_model_i.xfer({1'b1, a, 8'h00}, r);
  endtask : rd

  // Bounded wait on the fail-safe flag, then compare it
  task automatic wait_fs(input logic v, input int n);
    int k;
    k = 0;
    while (failsafe_o !== v && k < n) begin
      @(negedge clk_i);
      k++;
    end
    cmp8({7'h00, failsafe_o}, {7'h00, v});
  endtask : wait_fs

  // Main sequence
  initial begin
    {rst_i, pwm_i, nvm_access_req_i, nvm_use_req_i, nvm_unused_req_i} = {1'b1, 6'h00};
    {undervoltage_i, fail_silent_i, ovr} = 8'h18;
    {nv1, nv2, nv3} = {8'h11, 8'h22, 8'h33};
    cyc(5);
    rst_i = 1'b0;
    cyc(3);
    rd(lhm_pkg::ADDR_FSC, rb);
    cmp8(rb, 8'h00);
    cmp8(cur1, lhm_pkg::CUR_RST);
    // Shortest setting runs from reset and expires before a refresh can land
    wait_fs(1'b1, 200);
    lhm_host_model_i.exit_seq(3'h7);
    wait_fs(1'b0, 4);
    for (int c = 0; c < 8; c++) begin
      @(negedge clk_i);
      ovr = c[0] ? 6'h38 : 6'h18;  // Ch3 follows via 11 and 01
      lhm_host_model_i.refresh(c[2:0]);
      cyc((c + 1) * BASE - 20);
      cmp8({7'h00, failsafe_o}, 8'h00);
      wait_fs(1'b1, 40);
      cmp8(cur2, nv2);
      cyc(3);
      cmp8({5'h00, ch_on_o}, 8'h02);
      pwm_i = 3'h7;
      cyc(4);
      cmp8({5'h00, ch_on_o}, 8'h06);
      wr(lhm_pkg::ADDR_CUR1, 8'h5A);
      rd(lhm_pkg::ADDR_CUR1, rb);
      cmp8(rb, nv1);
      rd(lhm_pkg::ADDR_FSC, rb);
      cmp8(rb, {1'b1, lhm_pkg::EXIT_REFRESH, c[2:0], 1'b0});
      if (c == 0) begin
        wr(lhm_pkg::ADDR_FSC, {1'b0, lhm_pkg::EXIT_STEP1, 4'h0});
        wr(lhm_pkg::ADDR_FSC, {1'b0, lhm_pkg::EXIT_STEP2, 4'h0});
        wr(lhm_pkg::ADDR_FSC, {1'b0, lhm_pkg::EXIT_REFRESH, 4'h0});
        wr(lhm_pkg::ADDR_FSC, {1'b0, lhm_pkg::EXIT_STEP3, 4'h0});
        cmp8({7'h00, failsafe_o}, 8'h01);
        @(negedge clk_i);
        undervoltage_i = 1'b1;
        cyc(3);
        cmp8({5'h00, ch_on_o}, 8'h00);
        undervoltage_i = 1'b0;
        cyc(3);
        cmp8({5'h00, ch_on_o}, 8'h06);
      end
      // Longest time-out on exit leaves room before the next refresh
      lhm_host_model_i.exit_seq(3'h7);
      wait_fs(1'b0, 4);
      cmp8(cur2, nv2);
      @(negedge clk_i);
      pwm_i = 3'h5;
      cyc(4);
      cmp8({5'h00, ch_on_o}, 8'h05);
      pwm_i = 3'h0;
      wr(lhm_pkg::ADDR_CUR3, 8'hC3);
      cmp8(cur3, 8'hC3);
    end
    @(negedge clk_i);
    nvm_access_req_i = 1'b1;
    cyc(3300);
    cmp8({7'h00, failsafe_o}, 8'h00);
    {nvm_use_req_i, pwm_i} = 4'hF;
    cyc(4);
    cmp8({7'h00, nvm_allowed_o}, 8'h01);
    wr(lhm_pkg::ADDR_CUR1, 8'h96);
    rd(lhm_pkg::ADDR_CUR1, rb);
    cmp8(rb, 8'h96);
    cmp8({5'h00, ch_on_o}, 8'h00);
    rd(lhm_pkg::ADDR_FSC, rb);
    cmp8({7'h00, rb[0]}, 8'h01);
    @(negedge clk_i);
    {nvm_access_req_i, nvm_use_req_i} = 2'h0;
    cyc(500);
    cmp8({7'h00, nvm_allowed_o}, 8'h01);
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    cyc(3);
    cmp8({7'h00, nvm_allowed_o}, 8'h00);
    {nvm_access_req_i, nvm_unused_req_i} = 2'h3;
    cyc(4);
    cmp8({6'h00, nvm_allowed_o, ch_on_o[0]}, 8'h00);
    rst_i = 1'b1;
    {nvm_access_req_i, nvm_unused_req_i} = 2'h0;
    cyc(2);
    rst_i = 1'b0;
    cyc(4);
    cmp8({5'h00, ch_on_o}, 8'h07);
    fail_silent_i = 1'b1;
    cyc(1);
    fail_silent_i = 1'b0;
    cyc(6);
    cmp8({5'h00, ch_on_o}, 8'h00);
    close_out();
  end
endmodule : test_lhm_ctrl

bind lhm_ctrl lhm_ctrl_chk lhm_ctrl_chk_i (.clk_i, .rst_i, .csb_n_i, .sdo_oe_n_o,
  .nvm_access_req_i, .undervoltage_i, .fail_silent_i, .nv_current_ch1_i,
  .failsafe_channel_override_i, .led_current_ch1_o, .ch_on_o, .failsafe_o, .nvm_allowed_o);
